// *** hw/fcso_pkg.sv ***
// fcso_pkg: shared constants and types for the flame controller status outputs block
package fcso_pkg;
    localparam int FCSO_ZONES = 8;              // zones and detectors per controller
    localparam int FCSO_BUS_W = 8;              // width of the chained voting data bus
    // system status display codes
    localparam logic [3:0] FCSO_STAT_MAX_BIN = 4'h7; // highest code shown in binary
    localparam logic [3:0] FCSO_STAT_EIGHT = 4'h8;   // status 8 shows as all low
    // zone number codes
    localparam logic [3:0] FCSO_ZONE_EIGHT = 4'h8;   // zone 8 sets only bit 3
    // sticky event bit positions
    localparam int FCSO_EV_FAULT = 0;           // fault output dropped
    localparam int FCSO_EV_ACCEPT = 1;          // remote accept closure
    localparam int FCSO_EV_REMRST = 2;          // remote reset/inhibit closure
    localparam int FCSO_EV_STROBE = 3;          // upstream strobe seen
    localparam int FCSO_EV_W = 4;               // number of event bits
    // register indices on the plain register port
    localparam logic [3:0] FCSO_REG_CTRL = 4'h0;     // display codes and zone alarms
    localparam logic [3:0] FCSO_REG_LOGIC = 4'h1;    // fire logic, alarm, fault, bus out
    localparam logic [3:0] FCSO_REG_TEST = 4'h2;     // detector test drive
    localparam logic [3:0] FCSO_REG_STATUS = 4'h3;   // sticky event status (read only)
    localparam logic [3:0] FCSO_REG_CLEAR = 4'h4;    // write 1 to clear (write only)
    localparam logic [3:0] FCSO_REG_ENABLE = 4'h5;   // interrupt enable
    localparam logic [3:0] FCSO_REG_INPUTS = 4'h6;   // live inputs and upstream bus
    localparam logic [3:0] FCSO_REG_CONFIG = 4'h7;   // captured rocker switches
    localparam logic [3:0] FCSO_REG_LATCH = 4'h8;    // latched upstream bus
    // voting arrangement
    typedef enum logic [0:0] {
        FCSO_VOTE_SEPARATE = 1'b0,
        FCSO_VOTE_COMMON = 1'b1
    } fcso_vote_t;
    // switch capture sequence
    typedef enum logic [1:0] {
        FCSO_CAP_WAIT = 2'b00,
        FCSO_CAP_TAKE = 2'b01,
        FCSO_CAP_HOLD = 2'b10
    } fcso_cap_t;
endpackage

// *** hw/fcso_bus_latch.sv ***
// fcso_bus_latch: register that catches the upstream voting bus on each strobe
`timescale 1ns/1ps
module fcso_bus_latch
    import fcso_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // capture request
    input wire logic i_take,
    input wire logic [FCSO_BUS_W-1:0] i_data,
    // held word
    output logic [FCSO_BUS_W-1:0] o_data
);
    // word held from one strobe to the next; read data always comes from this flop
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_data <= '0;
        end else if (i_take) begin
            o_data <= i_data;
        end
    end
endmodule

// *** hw/fcso_top.sv ***
// fcso_top: status outputs, remote inputs and voting bus of a flame controller
// What this block does
// - zone number to binary lines, zone 8 bit3
// - status 0-7 binary, 8 and blank low
// - fault and inhibited bits per status table
// - fault output high when power ok, no fault and status 3, 6 or blank, low otherwise
// - remote reset contact resets or inhibits outputs
// - inhibited indicator on keylock or remote input
// - remote accept clears alarm only
// - shared pin: fire logic A or strobe
// - fire logic B driven in both arrangements
// - chained bus and strobe from previous controller
// - eight zone alarms and eight test drives
// - one test drive line per detector
`timescale 1ns/1ps
module fcso_top
    import fcso_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // field inputs, closure means contact made to ground (active high here)
    input wire logic i_remote_reset_inhibit,
    input wire logic i_remote_accept,
    input wire logic i_keylock_inhibit,
    input wire logic i_power_ok,
    // rocker switch banks, one bit per rocker, closed = 1
    input wire logic [31:0] i_rockers,
    // chained voting input
    input wire logic [FCSO_BUS_W-1:0] i_data_bus_in,
    input wire logic i_data_strobe_in,
    // zone and detector outputs
    output logic [FCSO_ZONES-1:0] o_zone_alarm,
    output logic [FCSO_ZONES-1:0] o_detector_test_drive,
    // system outputs
    output logic o_fire_logic_a_strobe,
    output logic o_fire_logic_b,
    output logic o_alarm,
    output logic o_fault,
    output logic o_outputs_inhibited,
    output logic o_controller_reset,
    output logic [FCSO_BUS_W-1:0] o_data_bus_out,
    // status lines: [3:0] zone code, [4] unused, [7:5] system status
    output logic [7:0] o_status_lines,
    // interrupt
    output logic o_irq
);
    // software-written state
    logic [3:0] zone_num_reg;         // displayed zone 1..8
    logic [3:0] sys_stat_reg;         // displayed system status 0..8
    logic stat_blank_reg;             // display blank
    logic [FCSO_ZONES-1:0] zone_req_reg;  // zone alarms wanted by the logic
    logic fla_reg;                    // fire logic A level
    logic flb_reg;                    // fire logic B level
    logic alarm_req_reg;              // alarm set request
    logic fault_cond_reg;             // a fault exists
    logic strobe_reg;                 // strobe for common voting
    logic [FCSO_BUS_W-1:0] bus_out_reg;   // outgoing voting word
    logic [FCSO_ZONES-1:0] test_reg;  // detector test drive
    logic [FCSO_EV_W-1:0] stat_reg;   // sticky events
    logic [FCSO_EV_W-1:0] en_reg;     // interrupt enables
    logic alarm_reg;                  // alarm output state
    logic [31:0] cfg_reg;             // captured switches
    fcso_cap_t cap_reg;               // capture state
    logic fault_q_reg;                // previous fault output
    logic acc_q_reg;                  // previous accept level
    logic rem_q_reg;                  // previous remote level
    logic [31:0] rdata_next;          // read mux
    logic [FCSO_BUS_W-1:0] bus_held;  // latched upstream word
    logic [FCSO_EV_W-1:0] ev_now;     // events this cycle
    logic inhibit;                    // outputs inhibited
    fcso_vote_t vote;                 // arrangement from switches
    logic [2:0] sys_bits;             // encoded status bits
    logic [3:0] zone_bits;            // encoded zone bits
    logic sel_wr;                     // any write this cycle

    assign sel_wr = i_wr;
    // voting arrangement comes from the captured rocker, never the live one
    assign vote = fcso_vote_t'(cfg_reg[31]);

    // software-driven control registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            zone_num_reg <= 4'h1;
            sys_stat_reg <= 4'h0;
            stat_blank_reg <= 1'b1;
            zone_req_reg <= '0;
            fla_reg <= 1'b0;
            flb_reg <= 1'b0;
            alarm_req_reg <= 1'b0;
            fault_cond_reg <= 1'b0;
            strobe_reg <= 1'b0;
            bus_out_reg <= '0;
            test_reg <= '0;
            en_reg <= '0;
        end else if (sel_wr) begin
            case (i_addr)
                FCSO_REG_CTRL: begin
                    zone_num_reg <= i_wdata[3:0];
                    sys_stat_reg <= i_wdata[7:4];
                    stat_blank_reg <= i_wdata[8];
                    zone_req_reg <= i_wdata[23:16];
                end
                FCSO_REG_LOGIC: begin
                    fla_reg <= i_wdata[0];
                    flb_reg <= i_wdata[1];
                    alarm_req_reg <= i_wdata[2];
                    fault_cond_reg <= i_wdata[3];
                    strobe_reg <= i_wdata[4];
                    bus_out_reg <= i_wdata[15:8];
                end
                FCSO_REG_TEST: begin
                    test_reg <= i_wdata[FCSO_ZONES-1:0];
                end
                FCSO_REG_ENABLE: begin
                    en_reg <= i_wdata[FCSO_EV_W-1:0];
                end
                default: begin
                    // other offsets are read only or write-one-clear
                end
            endcase
        end
    end

    // rockers caught on the second clock edge after reset release, then frozen
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cap_reg <= FCSO_CAP_WAIT;
            cfg_reg <= '0;
        end else begin
            case (cap_reg)
                FCSO_CAP_WAIT: cap_reg <= FCSO_CAP_TAKE;
                FCSO_CAP_TAKE: begin
                    cfg_reg <= i_rockers;
                    cap_reg <= FCSO_CAP_HOLD;
                end
                FCSO_CAP_HOLD: cap_reg <= FCSO_CAP_HOLD; // later changes ignored
                default: cap_reg <= FCSO_CAP_WAIT;
            endcase
        end
    end

    // inhibit from keylock or remote contact
    assign inhibit = i_keylock_inhibit | i_remote_reset_inhibit;

    // alarm: set by request, dropped on accept without touching zones
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            alarm_reg <= 1'b0;
        end else if (i_remote_accept) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_req_reg;
        end
    end

    // edge history for events
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fault_q_reg <= 1'b0; // same as the pin's reset level, so no false drop
            acc_q_reg <= 1'b0;
            rem_q_reg <= 1'b0;
        end else begin
            fault_q_reg <= o_fault;
            acc_q_reg <= i_remote_accept;
            rem_q_reg <= i_remote_reset_inhibit;
        end
    end

    always_comb begin
        ev_now = '0;
        ev_now[FCSO_EV_FAULT] = fault_q_reg & ~o_fault;
        ev_now[FCSO_EV_ACCEPT] = i_remote_accept & ~acc_q_reg;
        ev_now[FCSO_EV_REMRST] = i_remote_reset_inhibit & ~rem_q_reg;
        ev_now[FCSO_EV_STROBE] = i_data_strobe_in & (vote == FCSO_VOTE_COMMON);
    end

    // sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_reg <= '0;
        end else if (i_wr && i_addr == FCSO_REG_CLEAR) begin
            stat_reg <= (stat_reg & ~i_wdata[FCSO_EV_W-1:0]) | ev_now;
        end else begin
            stat_reg <= stat_reg | ev_now;
        end
    end

    assign o_irq = |(stat_reg & en_reg);

    // upstream word caught on each strobe in common voting
    fcso_bus_latch u_latch (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_take(i_data_strobe_in && vote == FCSO_VOTE_COMMON),
        .i_data(i_data_bus_in),
        .o_data(bus_held)
    );

    // zone code: 1..7 binary, 8 only bit 3
    always_comb begin
        if (zone_num_reg == FCSO_ZONE_EIGHT) begin
            zone_bits = 4'h8;
        end else begin
            zone_bits = {1'b0, zone_num_reg[2:0]};
        end
    end

    // status code: 0..7 binary, 8 and blank all low
    always_comb begin
        if (stat_blank_reg || sys_stat_reg > FCSO_STAT_MAX_BIN) begin
            sys_bits = 3'h0;
        end else begin
            sys_bits = sys_stat_reg[2:0];
        end
    end

    // registered pin outputs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_status_lines <= '0;
            o_zone_alarm <= '0;
            o_detector_test_drive <= '0;
            o_fire_logic_a_strobe <= 1'b0;
            o_fire_logic_b <= 1'b0;
            o_alarm <= 1'b0;
            o_fault <= 1'b0;
            o_outputs_inhibited <= 1'b0;
            o_controller_reset <= 1'b0;
            o_data_bus_out <= '0;
        end else begin
            o_status_lines <= {sys_bits, 1'b0, zone_bits};
            o_zone_alarm <= inhibit ? '0 : zone_req_reg;
            o_detector_test_drive <= test_reg & cfg_reg[FCSO_ZONES-1:0];
            o_fire_logic_a_strobe <= (vote == FCSO_VOTE_COMMON) ? strobe_reg
                                   : (fla_reg & ~inhibit);
            o_fire_logic_b <= flb_reg & ~inhibit;
            o_alarm <= alarm_reg & ~inhibit;
            // fault bit per status table: high only for 3, 6 and blank
            o_fault <= i_power_ok & ~fault_cond_reg
                     & (stat_blank_reg | (sys_stat_reg == 4'h3) | (sys_stat_reg == 4'h6));
            // inhibited also for status 0, 1, 7, 8
            o_outputs_inhibited <= inhibit | (~stat_blank_reg &&
                (sys_stat_reg <= 4'h1 || sys_stat_reg == FCSO_STAT_MAX_BIN
                 || sys_stat_reg == FCSO_STAT_EIGHT));
            o_controller_reset <= i_remote_reset_inhibit & ~rem_q_reg;
            o_data_bus_out <= bus_out_reg;
        end
    end

    // read mux, data one cycle later
    always_comb begin
        rdata_next = '0;
        case (i_addr)
            FCSO_REG_CTRL: rdata_next = {8'h0, zone_req_reg, 7'h0, stat_blank_reg,
                                         sys_stat_reg, zone_num_reg};
            FCSO_REG_LOGIC: rdata_next = {16'h0, bus_out_reg, 3'h0, strobe_reg,
                                          fault_cond_reg, alarm_req_reg, flb_reg, fla_reg};
            FCSO_REG_TEST: rdata_next = {24'h0, test_reg};
            FCSO_REG_STATUS: rdata_next = {28'h0, stat_reg};
            FCSO_REG_ENABLE: rdata_next = {28'h0, en_reg};
            FCSO_REG_INPUTS: rdata_next = {16'h0, i_data_bus_in, 3'h0, i_power_ok,
                                           i_keylock_inhibit, i_remote_accept,
                                           i_remote_reset_inhibit, i_data_strobe_in};
            FCSO_REG_CONFIG: rdata_next = cfg_reg;
            FCSO_REG_LATCH: rdata_next = {24'h0, bus_held};
            default: rdata_next = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= '0;
        end
    end

    // checks
    property p_zone8;
        @(posedge i_clk) disable iff (!i_reset_n)
        zone_num_reg == FCSO_ZONE_EIGHT |=> o_status_lines[3:0] == 4'h8;
    endproperty
    a_zone8: assert property (p_zone8) else $error("zone 8 code wrong");
    property p_stat_blank;
        @(posedge i_clk) disable iff (!i_reset_n)
        (stat_blank_reg || sys_stat_reg == FCSO_STAT_EIGHT) |=> o_status_lines[7:5] == 3'h0;
    endproperty
    a_stat_blank: assert property (p_stat_blank) else $error("status lines not low");
    property p_stat3;
        @(posedge i_clk) disable iff (!i_reset_n)
        (!stat_blank_reg && sys_stat_reg == 4'h3 && i_power_ok && !fault_cond_reg) |=> o_fault;
    endproperty
    a_stat3: assert property (p_stat3) else $error("status 3 fault bit low");
    property p_power;
        @(posedge i_clk) disable iff (!i_reset_n)
        !i_power_ok |=> !o_fault;
    endproperty
    a_power: assert property (p_power) else $error("fault output high without power");
    property p_inhib;
        @(posedge i_clk) disable iff (!i_reset_n)
        (i_keylock_inhibit || i_remote_reset_inhibit) |=> o_outputs_inhibited && o_zone_alarm == '0;
    endproperty
    a_inhib: assert property (p_inhib) else $error("inhibit not shown");
    property p_accept;
        @(posedge i_clk) disable iff (!i_reset_n)
        i_remote_accept |=> ##1 !o_alarm;
    endproperty
    a_accept: assert property (p_accept) else $error("alarm not cleared on accept");
    property p_strobe;
        @(posedge i_clk) disable iff (!i_reset_n)
        vote == FCSO_VOTE_COMMON |=> o_fire_logic_a_strobe == $past(strobe_reg);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe pin wrong");
    property p_cfg_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        cap_reg == FCSO_CAP_HOLD |=> $stable(cfg_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("switches changed while running");
    c_accept: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_alarm ##1 i_remote_accept);
    c_strobe: cover property (@(posedge i_clk) disable iff (!i_reset_n) ev_now[FCSO_EV_STROBE]);
    c_irq: cover property (@(posedge i_clk) disable iff (!i_reset_n) o_irq);
endmodule

// *** verification/fcso_chain_model.sv ***
// fcso_chain_model: upstream controller of the voting chain, source of bus and strobe
`timescale 1ns/1ps
module fcso_chain_model
    import fcso_pkg::*;
(
    // clock
    input wire logic i_clk,
    // bench command: offer one word
    input wire logic i_send,
    input wire logic [FCSO_BUS_W-1:0] i_word,
    // outgoing bus and strobe toward the block
    output logic [FCSO_BUS_W-1:0] o_bus,
    output logic o_strobe
);
    // quiet start, no strobe before the bench asks
    initial begin
        o_bus = 8'h00;
        o_strobe = 1'b0;
    end
    // word and strobe leave together on one edge
    // released bus toggles every cycle so a stale word cannot pass for data
    always @(posedge i_clk) begin
        if (i_send) begin // word offered with its strobe
            o_bus <= i_word;
            o_strobe <= 1'b1;
        end else begin // released: changing pattern, strobe low
            o_bus <= ~o_bus;
            o_strobe <= 1'b0;
        end
    end
endmodule

// *** verification/tb_top.sv ***
// tb_top: self-checking bench for the flame controller status outputs block
`timescale 1ns/1ps
module tb_top
    import fcso_pkg::*;
;
    // design inputs, all set at time zero
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_remote_reset_inhibit = 1'b0;
    logic i_remote_accept = 1'b0;
    logic i_keylock_inhibit = 1'b0;
    logic i_power_ok = 1'b1;
    logic [31:0] i_rockers = 32'h0;
    logic send = 1'b0;
    logic [7:0] word = 8'h00;
    // upstream bus from the model
    logic [7:0] up_bus;
    logic up_strobe;
    // design outputs
    logic [31:0] o_rdata;
    logic [7:0] o_zone_alarm, o_detector_test_drive, o_data_bus_out, o_status_lines;
    logic o_fire_logic_a_strobe, o_fire_logic_b, o_alarm, o_fault;
    logic o_outputs_inhibited, o_controller_reset, o_irq;
    // bench state
    int seed = 38378;
    int fail_count = 0;
    int n_checks = 0;
    int s;
    logic [31:0] rk, lg;
    logic [7:0] zr, t;
    logic [3:0] z;
    logic b;

    always #5 i_clk = ~i_clk;

    fcso_top dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_remote_reset_inhibit(i_remote_reset_inhibit), .i_remote_accept(i_remote_accept),
        .i_keylock_inhibit(i_keylock_inhibit), .i_power_ok(i_power_ok),
        .i_rockers(i_rockers), .i_data_bus_in(up_bus), .i_data_strobe_in(up_strobe),
        .o_zone_alarm(o_zone_alarm), .o_detector_test_drive(o_detector_test_drive),
        .o_fire_logic_a_strobe(o_fire_logic_a_strobe), .o_fire_logic_b(o_fire_logic_b),
        .o_alarm(o_alarm), .o_fault(o_fault), .o_outputs_inhibited(o_outputs_inhibited),
        .o_controller_reset(o_controller_reset), .o_data_bus_out(o_data_bus_out),
        .o_status_lines(o_status_lines), .o_irq(o_irq));

    fcso_chain_model chain_u (.i_clk(i_clk), .i_send(send), .i_word(word),
        .o_bus(up_bus), .o_strobe(up_strobe));

    // expected status lines: zone code low, status code high, bit 4 idle
    function automatic logic [7:0] exp_lines(input logic [3:0] zn, input logic [3:0] st,
                                             input logic bl);
        logic [2:0] sc;
        sc = (bl || st > FCSO_STAT_MAX_BIN) ? 3'h0 : st[2:0];
        return {sc, 1'b0, zn};
    endfunction
    // inhibited bit per status code, blank never inhibits
    function automatic logic exp_inh(input logic [3:0] st, input logic bl);
        return !bl && (st inside {4'h0, 4'h1, 4'h7, FCSO_STAT_EIGHT});
    endfunction
    // fault bit high only for status 3, 6 and a blank display
    function automatic logic exp_flt(input logic [3:0] st, input logic bl);
        return bl || st == 4'h3 || st == 4'h6;
    endfunction

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // word compare
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // single bit compare
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %b seen %b", nm, e, g);
            fail_count++;
        end
    endtask
    // let n edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle only
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk_word(nm, e, o_rdata);
    endtask
    // reset with a rocker setting, held four cycles
    task automatic do_reset(input logic [31:0] r);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        i_rockers <= r; // switches set while held in reset
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        tick(3);
    endtask
    // bounded wait for the controller reset pulse
    task automatic wait_rst();
        int k;
        k = 0;
        while (o_controller_reset !== 1'b1 && k < 6) begin
            tick(1);
            k++;
        end
        if (o_controller_reset !== 1'b1) begin // pulse never came: give up
            fail_count++;
            close_out();
        end
    endtask

    // hang guard
    initial begin
        #500000;
        fail_count++;
        close_out();
    end

    // main sequence
    initial begin
        rk = $random(seed);
        rk[31] = 1'b0; // separate voting first
        rk[30:28] = 3'h0; // rockers 4-5..4-7 unused, left open
        do_reset(rk);
        rd_chk(FCSO_REG_CONFIG, rk, "config");
        @(posedge i_clk);
        i_rockers <= ~rk; // switches moved while running must be ignored
        tick(3);
        rd_chk(FCSO_REG_CONFIG, rk, "config_held");
        // every status code, blank last, zones 1..8 along the way
        for (s = 0; s < 10; s++) begin
            z = 4'((s % 8) + 1);
            b = (s == 9);
            wr(FCSO_REG_CTRL, {23'h0, b, 4'(s), z});
            tick(3);
            chk_word("lines", {24'h0, exp_lines(z, 4'(s), b)}, {24'h0, o_status_lines});
            chk_bit("inhibited", exp_inh(4'(s), b), o_outputs_inhibited);
            chk_bit("fault", exp_flt(4'(s), b), o_fault);
        end
        wr(FCSO_REG_CLEAR, 32'hf);
        // random zone, logic and test-drive words under a blank display
        repeat (4) begin
            zr = 8'($random(seed));
            lg = $random(seed) & 32'h0000ff07;
            t = 8'($random(seed));
            wr(FCSO_REG_CTRL, {8'h0, zr, 7'h0, 1'b1, 8'h01});
            wr(FCSO_REG_LOGIC, lg);
            wr(FCSO_REG_TEST, {24'h0, t});
            tick(3);
            chk_word("zone_alarm", {24'h0, zr}, {24'h0, o_zone_alarm});
            chk_word("test_drive", {24'h0, t & rk[7:0]}, {24'h0, o_detector_test_drive});
            chk_word("bus_out", {24'h0, lg[15:8]}, {24'h0, o_data_bus_out});
            chk_bit("fire_a", lg[0], o_fire_logic_a_strobe);
            chk_bit("fire_b", lg[1], o_fire_logic_b);
            chk_bit("alarm", lg[2], o_alarm);
        end
        // remote accept drops only the alarm
        wr(FCSO_REG_CTRL, {8'h0, 8'hff, 7'h0, 1'b1, 8'h01});
        wr(FCSO_REG_LOGIC, 32'h7);
        @(posedge i_clk);
        i_remote_accept <= 1'b1;
        tick(4);
        chk_bit("alarm_acc", 1'b0, o_alarm);
        chk_word("zone_acc", 32'hff, {24'h0, o_zone_alarm});
        chk_bit("fire_a_acc", 1'b1, o_fire_logic_a_strobe);
        chk_bit("fire_b_acc", 1'b1, o_fire_logic_b);
        @(posedge i_clk);
        i_remote_accept <= 1'b0;
        tick(4);
        chk_bit("alarm_back", 1'b1, o_alarm);
        rd_chk(FCSO_REG_STATUS, 32'h2, "status_acc");
        wr(FCSO_REG_CLEAR, 32'hf);
        // remote reset/inhibit closure, then keylock
        @(posedge i_clk);
        i_remote_reset_inhibit <= 1'b1;
        wait_rst();
        tick(1);
        chk_bit("reset_pulse_end", 1'b0, o_controller_reset);
        tick(2);
        chk_bit("inh_remote", 1'b1, o_outputs_inhibited);
        chk_word("zone_inh", 32'h0, {24'h0, o_zone_alarm});
        @(posedge i_clk);
        i_remote_reset_inhibit <= 1'b0;
        i_keylock_inhibit <= 1'b1;
        tick(3);
        chk_bit("inh_key", 1'b1, o_outputs_inhibited);
        @(posedge i_clk);
        i_keylock_inhibit <= 1'b0;
        tick(3);
        chk_bit("inh_off", 1'b0, o_outputs_inhibited);
        rd_chk(FCSO_REG_STATUS, 32'h4, "status_rem");
        wr(FCSO_REG_CLEAR, 32'hf);
        // power loss and fault bit, interrupt raised, masked and cleared
        wr(FCSO_REG_ENABLE, 32'h1);
        @(posedge i_clk);
        i_power_ok <= 1'b0;
        tick(3);
        chk_bit("fault_pwr", 1'b0, o_fault);
        chk_bit("irq_on", 1'b1, o_irq);
        @(posedge i_clk);
        i_power_ok <= 1'b1;
        tick(3);
        chk_bit("fault_back", 1'b1, o_fault);
        wr(FCSO_REG_ENABLE, 32'h0);
        tick(1);
        chk_bit("irq_masked", 1'b0, o_irq);
        wr(FCSO_REG_CLEAR, 32'h1);
        rd_chk(FCSO_REG_STATUS, 32'h0, "status_clr");
        wr(FCSO_REG_ENABLE, 32'h1);
        wr(FCSO_REG_LOGIC, 32'h8);
        tick(3);
        chk_bit("fault_bit", 1'b0, o_fault);
        chk_bit("irq_fault", 1'b1, o_irq);
        wr(FCSO_REG_LOGIC, 32'h0);
        wr(FCSO_REG_CLEAR, 32'hf);
        wr(FCSO_REG_STATUS, 32'hff); // read-only place, write ignored
        tick(1);
        chk_bit("irq_clr", 1'b0, o_irq);
        rd_chk(FCSO_REG_STATUS, 32'h0, "status_ro");
        rd_chk(4'hc, 32'h0, "unmapped");
        // common voting: shared pin becomes the strobe, chained words latched
        rk[31] = 1'b1;
        do_reset(rk);
        wr(FCSO_REG_LOGIC, 32'h10);
        tick(3);
        chk_bit("strobe_out", 1'b1, o_fire_logic_a_strobe);
        wr(FCSO_REG_LOGIC, 32'h3);
        tick(3);
        chk_bit("strobe_not_a", 1'b0, o_fire_logic_a_strobe);
        chk_bit("fire_b_com", 1'b1, o_fire_logic_b);
        @(posedge i_clk);
        send <= 1'b1;
        word <= 8'($random(seed));
        @(posedge i_clk);
        word <= 8'h5a; // back-to-back second word wins
        @(posedge i_clk);
        send <= 1'b0;
        tick(4);
        rd_chk(FCSO_REG_LATCH, 32'h5a, "latch");
        rd_chk(FCSO_REG_STATUS, 32'h8, "status_strobe");
        close_out();
    end
endmodule
